//--- verilog/fsvop_defs.svh
`ifndef FSVOP_DEFS_SVH
`define FSVOP_DEFS_SVH

`define FSVOP_CMD_ERASE_VERIFY_SECT 8'h03
`define FSVOP_CMD_READ_ONCE 8'h04
`define FSVOP_CMD_PROGRAM_PHRASE 8'h06

`define FSVOP_IDX_EVS_LAST 3'h2
`define FSVOP_IDX_RONCE_LAST 3'h1
`define FSVOP_IDX_PROG_LAST 3'h5

`define FSVOP_ONCE_MAX_INDEX 16'h0007
`define FSVOP_ONCE_PHRASES 8

`define FSVOP_ADDR_LO_PFLASH 23'h400000
`define FSVOP_ADDR_HI_PFLASH 23'h7fffff
`define FSVOP_SECT_BOUND_BIT 17

`define FSVOP_REG_CMD_OBJ 3'h0
`define FSVOP_REG_INDEX 3'h1
`define FSVOP_REG_STATUS 3'h2
`define FSVOP_REG_CTRL 3'h3

`define FSVOP_ST_COMMAND_COMPLETE_FLAG 7
`define FSVOP_ST_ACCESS_ERROR_FLAG 5
`define FSVOP_ST_PROTECTION_VIOLATION_FLAG 4
`define FSVOP_ST_MG1 1
`define FSVOP_ST_MG0 0

`define FSVOP_CTRL_MODE_OK 0

`define FSVOP_STEP_CYCLES 4'h3

`endif

//--- verilog/fsvop_pkg.sv
package fsvop_pkg;
    typedef enum logic [2:0] {
        FSVOP_IDLE = 3'b000,
        FSVOP_CHECK = 3'b001,
        FSVOP_VERIFY = 3'b010,
        FSVOP_FETCH = 3'b011,
        FSVOP_WRITE = 3'b100,
        FSVOP_READBACK = 3'b101,
        FSVOP_DONE = 3'b110
    } fsvop_state_t;
endpackage

//--- verilog/fsvop_sync.sv
`timescale 1ns/1ps
module fsvop_sync (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // A change is taken once the second and third stages agree.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                dout <= s3_q;
            end
        end
    end
endmodule

//--- verilog/fsvop_addr_check.sv
`timescale 1ns/1ps
`include "fsvop_defs.svh"
module fsvop_addr_check
    import fsvop_pkg::*;
(
    input wire logic [22:0] start_addr,
    input wire logic [15:0] phrase_count,
    input wire logic check_section,
    output logic misaligned,
    output logic out_of_range,
    output logic crosses_bound
);
    logic [23:0] last_addr;

    always_comb begin
        last_addr = {1'b0, start_addr} + {5'h00, phrase_count, 3'h0} - 24'h000008;
        misaligned = (start_addr[2:0] != 3'h0);
        out_of_range = (start_addr < `FSVOP_ADDR_LO_PFLASH) ||
            (start_addr > `FSVOP_ADDR_HI_PFLASH);
        crosses_bound = 1'b0;
        if (check_section) begin
            crosses_bound = (phrase_count == 16'h0000) || last_addr[23] ||
                (last_addr[22:`FSVOP_SECT_BOUND_BIT] !=
                start_addr[22:`FSVOP_SECT_BOUND_BIT]);
        end
    end
endmodule

//--- verilog/fsvop_seq.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "fsvop_defs.svh"
module fsvop_seq
    import fsvop_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic cmd_mode_ok,
    input wire logic prot_region,
    output logic [22:0] flash_addr,
    output logic [63:0] flash_wdata,
    output logic flash_rd,
    output logic flash_wr,
    output logic flash_once_sel,
    input wire logic [63:0] flash_rdata,
    input wire logic flash_rd_err,
    input wire logic flash_rd_uncorr,
    output logic flash_busy,
    output logic block_read_invalid
);
    logic [15:0] cmd_obj_q [0:5];
    logic [2:0] command_index_q;
    logic command_complete_flag_q;
    logic access_error_flag_q;
    logic protection_violation_flag_q;
    logic verify_error_flag_q;
    logic uncorrectable_error_flag_q;
    logic mode_enable_q;
    fsvop_state_t state_q;
    fsvop_state_t state_d;
    logic [15:0] count_q;
    logic [22:0] addr_q;
    logic [3:0] wait_q;
    logic launch;
    logic mode_ok_sync;
    logic [22:0] cmd_addr;
    logic misaligned;
    logic out_of_range;
    logic crosses_bound;
    logic is_evs;
    logic [7:0] cmd_code;
    logic bad_launch;
    logic prot_hit;
    logic step_done;
    logic [15:0] status_word;
    logic [63:0] prog_data;

    fsvop_sync u_mode_sync (
        .mclk(mclk),
        .rst(rst),
        .din(cmd_mode_ok),
        .dout(mode_ok_sync)
    );

    assign cmd_code = cmd_obj_q[0][15:8];
    assign cmd_addr = {cmd_obj_q[0][6:0], cmd_obj_q[1]};
    assign is_evs = (cmd_code == `FSVOP_CMD_ERASE_VERIFY_SECT);
    assign prog_data = {cmd_obj_q[2], cmd_obj_q[3], cmd_obj_q[4], cmd_obj_q[5]};

    fsvop_addr_check u_addr_check (
        .start_addr(cmd_addr),
        .phrase_count(cmd_obj_q[2]),
        .check_section(is_evs),
        .misaligned(misaligned),
        .out_of_range(out_of_range),
        .crosses_bound(crosses_bound)
    );

    // Launch is a write of one to the complete flag position while idle with no access error or protection violation flag set.
    assign launch = reg_wr && (reg_addr == `FSVOP_REG_STATUS) &&
        reg_wdata[`FSVOP_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_q &&
        !access_error_flag_q && !protection_violation_flag_q;

    assign prot_hit = (cmd_code == `FSVOP_CMD_PROGRAM_PHRASE) && prot_region;

    always_comb begin
        bad_launch = 1'b0;
        if (!(mode_ok_sync && mode_enable_q)) begin
            bad_launch = 1'b1;
        end
        case (cmd_code)
            `FSVOP_CMD_ERASE_VERIFY_SECT: begin
                if (command_index_q != `FSVOP_IDX_EVS_LAST) begin
                    bad_launch = 1'b1;
                end
                if (crosses_bound) begin
                    bad_launch = 1'b1;
                end
                if (misaligned || out_of_range) begin
                    bad_launch = 1'b1;
                end
            end
            `FSVOP_CMD_READ_ONCE: begin
                if (command_index_q != `FSVOP_IDX_RONCE_LAST) begin
                    bad_launch = 1'b1;
                end
                if (cmd_obj_q[1] > `FSVOP_ONCE_MAX_INDEX) begin
                    bad_launch = 1'b1;
                end
            end
            `FSVOP_CMD_PROGRAM_PHRASE: begin
                if (command_index_q != `FSVOP_IDX_PROG_LAST) begin
                    bad_launch = 1'b1;
                end
                if (misaligned || out_of_range) begin
                    bad_launch = 1'b1;
                end
            end
            default: begin
                bad_launch = 1'b1;
            end
        endcase
    end

    assign step_done = (wait_q == 4'h0);

    always_comb begin
        state_d = state_q;
        case (state_q)
            FSVOP_IDLE: begin
                if (launch) begin
                    state_d = FSVOP_CHECK;
                end
            end
            FSVOP_CHECK: begin
                if (bad_launch || prot_hit) begin
                    state_d = FSVOP_DONE;
                end else if (is_evs) begin
                    state_d = FSVOP_VERIFY;
                end else if (cmd_code == `FSVOP_CMD_READ_ONCE) begin
                    state_d = FSVOP_FETCH;
                end else begin
                    state_d = FSVOP_WRITE;
                end
            end
            FSVOP_VERIFY: begin
                if (step_done && (count_q == 16'h0001)) begin
                    state_d = FSVOP_DONE;
                end
            end
            FSVOP_FETCH: begin
                if (step_done) begin
                    state_d = FSVOP_DONE;
                end
            end
            FSVOP_WRITE: begin
                if (step_done) begin
                    state_d = FSVOP_READBACK;
                end
            end
            FSVOP_READBACK: begin
                if (step_done) begin
                    state_d = FSVOP_DONE;
                end
            end
            FSVOP_DONE: begin
                state_d = FSVOP_IDLE;
            end
            default: begin
                state_d = FSVOP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= FSVOP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Step timer paces each array access.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_q <= 4'h0;
        end else if (state_q != state_d || (step_done && state_q == FSVOP_VERIFY)) begin
            wait_q <= `FSVOP_STEP_CYCLES;
        end else if (!step_done) begin
            wait_q <= wait_q - 4'h1;
        end
    end

    // Address and phrase count walk through the section.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            addr_q <= 23'h000000;
            count_q <= 16'h0000;
        end else if (state_q == FSVOP_CHECK) begin
            addr_q <= (cmd_code == `FSVOP_CMD_READ_ONCE) ?
                {20'h00000, cmd_obj_q[1][2:0]} : cmd_addr;
            count_q <= cmd_obj_q[2];
        end else if (state_q == FSVOP_VERIFY && step_done) begin
            addr_q <= addr_q + 23'h000008;
            count_q <= count_q - 16'h0001;
        end
    end

    assign flash_addr = addr_q;
    assign flash_wdata = prog_data;
    assign flash_wr = (state_q == FSVOP_WRITE) && step_done;
    assign flash_rd = step_done && ((state_q == FSVOP_VERIFY) ||
        (state_q == FSVOP_FETCH) || (state_q == FSVOP_READBACK));
    assign flash_once_sel = (state_q == FSVOP_FETCH);
    assign flash_busy = !command_complete_flag_q;
    assign block_read_invalid = (state_q == FSVOP_FETCH);

    // Command object words, command index and read-once result.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) begin
                cmd_obj_q[i] <= 16'h0000;
            end
            command_index_q <= 3'h0;
        end else if (state_q == FSVOP_FETCH && flash_rd) begin
            cmd_obj_q[2] <= flash_rdata[63:48];
            cmd_obj_q[3] <= flash_rdata[47:32];
            cmd_obj_q[4] <= flash_rdata[31:16];
            cmd_obj_q[5] <= flash_rdata[15:0];
        end else if (reg_wr && command_complete_flag_q) begin
            if (reg_addr == `FSVOP_REG_CMD_OBJ && command_index_q <= 3'h5) begin
                cmd_obj_q[command_index_q] <= reg_wdata;
            end
            if (reg_addr == `FSVOP_REG_INDEX) begin
                command_index_q <= reg_wdata[2:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_enable_q <= 1'b1;
        end else if (reg_wr && reg_addr == `FSVOP_REG_CTRL) begin
            mode_enable_q <= reg_wdata[`FSVOP_CTRL_MODE_OK];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            command_complete_flag_q <= 1'b1;
        end else if (state_q == FSVOP_DONE) begin
            command_complete_flag_q <= 1'b1;
        end else if (launch) begin
            command_complete_flag_q <= 1'b0;
        end
    end

    // Error flags: hardware set wins over a software write-one clear.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            access_error_flag_q <= 1'b0;
            protection_violation_flag_q <= 1'b0;
        end else begin
            if (state_q == FSVOP_CHECK && bad_launch) begin
                access_error_flag_q <= 1'b1;
            end else if (reg_wr && reg_addr == `FSVOP_REG_STATUS &&
                reg_wdata[`FSVOP_ST_ACCESS_ERROR_FLAG]) begin
                access_error_flag_q <= 1'b0;
            end
            if (state_q == FSVOP_CHECK && !bad_launch && prot_hit) begin
                protection_violation_flag_q <= 1'b1;
            end else if (reg_wr && reg_addr == `FSVOP_REG_STATUS &&
                reg_wdata[`FSVOP_ST_PROTECTION_VIOLATION_FLAG]) begin
                protection_violation_flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            verify_error_flag_q <= 1'b0;
            uncorrectable_error_flag_q <= 1'b0;
        end else if (launch) begin
            verify_error_flag_q <= 1'b0;
            uncorrectable_error_flag_q <= 1'b0;
        end else if (flash_rd) begin
            if (flash_rd_err || (state_q == FSVOP_VERIFY && flash_rdata != 64'hffffffffffffffff) ||
                (state_q == FSVOP_READBACK && flash_rdata != prog_data)) begin
                verify_error_flag_q <= 1'b1;
            end
            if (flash_rd_uncorr) begin
                uncorrectable_error_flag_q <= 1'b1;
            end
        end
    end

    assign status_word = {8'h00, command_complete_flag_q, 1'b0, access_error_flag_q,
        protection_violation_flag_q, 2'b00, verify_error_flag_q, uncorrectable_error_flag_q};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `FSVOP_REG_CMD_OBJ: begin
                    reg_rdata <= (command_index_q <= 3'h5) ? cmd_obj_q[command_index_q] : 16'h0000;
                end
                `FSVOP_REG_INDEX: begin
                    reg_rdata <= {13'h0000, command_index_q};
                end
                `FSVOP_REG_STATUS: begin
                    reg_rdata <= status_word;
                end
                `FSVOP_REG_CTRL: begin
                    reg_rdata <= {15'h0000, mode_enable_q};
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

//--- test/fsvop_seq_asserts.sv
`timescale 1ns/1ps
`include "fsvop_defs.svh"
module fsvop_seq_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic cmd_mode_ok,
    input wire logic prot_region,
    input wire logic [22:0] flash_addr,
    input wire logic [63:0] flash_wdata,
    input wire logic flash_rd,
    input wire logic flash_wr,
    input wire logic flash_once_sel,
    input wire logic [63:0] flash_rdata,
    input wire logic flash_rd_err,
    input wire logic flash_rd_uncorr,
    input wire logic flash_busy,
    input wire logic block_read_invalid
);
    logic launch_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            launch_q <= 1'b0;
        end else begin
            launch_q <= reg_wr && reg_addr == `FSVOP_REG_STATUS && reg_wdata[`FSVOP_ST_COMMAND_COMPLETE_FLAG];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_write;
        flash_wr;
    endsequence
    sequence s_readback;
        flash_rd && !flash_once_sel;
    endsequence
    property p_start;
        $rose(flash_busy) |-> launch_q;
    endproperty
    a_start: assert property (p_start) else $error("busy rose without a launch");
    property p_rd_busy;
        flash_rd |-> flash_busy;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("array read while idle");
    property p_wr_busy;
        s_write |-> flash_busy && !flash_once_sel;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("array write while idle");
    property p_wr_align;
        s_write |-> flash_addr[2:0] == 3'h0;
    endproperty
    a_wr_align: assert property (p_wr_align) else $error("misaligned program");
    property p_wr_range;
        s_write |-> flash_addr >= `FSVOP_ADDR_LO_PFLASH && flash_addr <= `FSVOP_ADDR_HI_PFLASH;
    endproperty
    a_wr_range: assert property (p_wr_range) else $error("program outside flash");
    property p_once_idx;
        flash_rd && flash_once_sel |-> flash_addr <= 23'h000007;
    endproperty
    a_once_idx: assert property (p_once_idx) else $error("reserved index too big");
    property p_invalid;
        block_read_invalid |-> flash_busy && !flash_wr;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid flag while idle");
    property p_readback;
        s_write |-> ##[1:8] s_readback;
    endproperty
    a_readback: assert property (p_readback) else $error("no read-back after write");
    property p_hold;
        s_write |-> flash_busy [*5];
    endproperty
    a_hold: assert property (p_hold) else $error("completed before read-back");
endmodule
bind fsvop_seq fsvop_seq_asserts fsvop_seq_asserts_i (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cmd_mode_ok(cmd_mode_ok), .prot_region(prot_region),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rd(flash_rd),
    .flash_wr(flash_wr), .flash_once_sel(flash_once_sel), .flash_rdata(flash_rdata),
    .flash_rd_err(flash_rd_err), .flash_rd_uncorr(flash_rd_uncorr),
    .flash_busy(flash_busy), .block_read_invalid(block_read_invalid));

//--- test/fsvop_seq_test.sv
`timescale 1ns/1ps
module fsvop_seq_test;
    typedef struct packed {
        logic [15:0] w0;
        logic [15:0] w1;
        logic [15:0] w2;
        logic [2:0] last;
        logic [4:0] f;
        logic [7:0] st;
    } fsvop_row_t;
    localparam logic [63:0] data_pat = 64'h1234_5678_9abc_def0;
    logic mclk, rst, reg_wr, reg_rd, cmd_mode_ok, prot_region, flash_rd_err, flash_rd_uncorr;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, v;
    logic [22:0] flash_addr, once_addr, wr_addr;
    logic [63:0] flash_wdata, flash_rdata, wr_seen;
    logic flash_rd, flash_wr, flash_once_sel, flash_busy, block_read_invalid, inv_seen;
    int n_fail, n_checks, ops;
    fsvop_row_t rows [22];
    fsvop_row_t row;
    fsvop_seq fsvop_seq_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_mode_ok(cmd_mode_ok),
        .prot_region(prot_region), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_once_sel(flash_once_sel),
        .flash_rdata(flash_rdata), .flash_rd_err(flash_rd_err),
        .flash_rd_uncorr(flash_rd_uncorr), .flash_busy(flash_busy),
        .block_read_invalid(block_read_invalid));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Records what the array side sees during a command.
    always @(posedge mclk) begin
        if (flash_wr) wr_seen <= flash_wdata;
        if (flash_wr) wr_addr <= flash_addr;
        if (block_read_invalid) inv_seen <= 1'b1;
        if (flash_rd && flash_once_sel) once_addr <= flash_addr;
        if (flash_rd || flash_wr) ops <= ops + 1;
    end
    task automatic wrap_up;
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        #1;
        while (flash_busy !== 1'b0 && k < 2000) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (flash_busy !== 1'b0) begin
            n_fail++;
            $display("ERROR busy expected 0 seen %b", flash_busy);
            wrap_up();
        end
    endtask
    function automatic logic [15:0] word_of(fsvop_row_t r, int i);
        if (i == 0) return r.w0;
        if (i == 1) return r.w1;
        if (r.w0[15:8] == 8'h06) return data_pat[95 - 16 * i -: 16];
        return r.w2;
    endfunction
    task automatic load(input fsvop_row_t r);
        for (int i = 0; i <= int'(r.last); i++) begin
            wr(3'h1, 16'(i));
            wr(3'h0, word_of(r, i));
        end
        wr(3'h1, {13'h0000, r.last});
    endtask
    initial begin
        n_fail = 0;
        n_checks = 0;
        ops = 0;
        inv_seen = 1'b0;
        once_addr = '0;
        wr_seen = '0;
        wr_addr = '0;
        rst = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmd_mode_ok = 1'b1;
        prot_region = 1'b0;
        flash_rdata = 64'h0;
        flash_rd_err = 1'b0;
        flash_rd_uncorr = 1'b0;
        rows = '{
            '{16'h0340, 16'h0000, 16'h0004, 3'h2, 5'h00, 8'h80},
            '{16'h0340, 16'h0000, 16'h0004, 3'h1, 5'h00, 8'ha0},
            '{16'h0341, 16'hfff8, 16'h0002, 3'h2, 5'h00, 8'ha0},
            '{16'h0341, 16'hfff8, 16'h0001, 3'h2, 5'h00, 8'h80},
            '{16'h0340, 16'h0004, 16'h0001, 3'h2, 5'h00, 8'ha0},
            '{16'h033f, 16'h0000, 16'h0001, 3'h2, 5'h00, 8'ha0},
            '{16'h0340, 16'h0000, 16'h0002, 3'h2, 5'h04, 8'h82},
            '{16'h0340, 16'h0000, 16'h0002, 3'h2, 5'h03, 8'h83},
            '{16'h0340, 16'h0000, 16'h0001, 3'h2, 5'h10, 8'ha0},
            '{16'h0400, 16'h0003, 16'h0000, 3'h1, 5'h00, 8'h80},
            '{16'h0400, 16'h0003, 16'h0000, 3'h2, 5'h00, 8'ha0},
            '{16'h0400, 16'h0008, 16'h0000, 3'h1, 5'h00, 8'ha0},
            '{16'h0400, 16'h0007, 16'h0000, 3'h1, 5'h03, 8'h83},
            '{16'h0400, 16'h0000, 16'h0000, 3'h1, 5'h10, 8'ha0},
            '{16'h0640, 16'h0008, 16'h0000, 3'h5, 5'h00, 8'h80},
            '{16'h0640, 16'h0008, 16'h0000, 3'h4, 5'h00, 8'ha0},
            '{16'h0640, 16'h0009, 16'h0000, 3'h5, 5'h00, 8'ha0},
            '{16'h0640, 16'h0008, 16'h0000, 3'h5, 5'h08, 8'h90},
            '{16'h0640, 16'h0008, 16'h0000, 3'h5, 5'h04, 8'h82},
            '{16'h0640, 16'h0008, 16'h0000, 3'h5, 5'h10, 8'ha0},
            '{16'h0600, 16'h0000, 16'h0000, 3'h5, 5'h00, 8'ha0},
            '{16'h0500, 16'h0000, 16'h0000, 3'h0, 5'h00, 8'ha0}};
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(3'h2, v);
        chk("status_reset", 16'h0080, v);
        rd(3'h3, v);
        chk("ctrl_reset", 16'h0001, v);
        for (int r = 0; r < 22; r++) begin
            row = rows[r];
            flash_rdata <= row.f[2] ? 64'h0 : (row.w0[15:8] == 8'h03 ? '1 : data_pat);
            flash_rd_err <= row.f[1];
            flash_rd_uncorr <= row.f[0];
            prot_region <= row.f[3];
            cmd_mode_ok <= !row.f[4];
            wr(3'h3, {15'h0, !row.f[4]});
            load(row);
            ops <= 0;
            inv_seen <= 1'b0;
            wr(3'h2, 16'h0080);
            wait_done();
            rd(3'h2, v);
            chk("status", {8'h00, row.st}, v);
            if (row.st[5] || row.st[4]) chk("array_ops", 0, ops);
            if (row.st == 8'h80 && row.w0[15:8] == 8'h03) chk("reads", row.w2, ops);
            if (row.st == 8'h80 && row.w0[15:8] == 8'h06) begin
                chk("prog_ops", 2, ops);
                chk("prog_data", data_pat, wr_seen);
                chk("prog_addr", {row.w0[6:0], row.w1}, wr_addr);
            end
            if (row.st == 8'h80 && row.w0[15:8] == 8'h04) begin
                chk("invalid_seen", 1, inv_seen);
                chk("once_addr", row.w1[2:0], once_addr);
                for (int i = 2; i < 6; i++) begin
                    wr(3'h1, 16'(i));
                    rd(3'h0, v);
                    chk("once_word", data_pat[95 - 16 * i -: 16], v);
                end
            end
            wr(3'h2, 16'h0030);
        end
        load('{16'h0500, 16'h0000, 16'h0000, 3'h0, 5'h00, 8'h00});
        wr(3'h2, 16'h0080);
        wait_done();
        wr(3'h2, 16'h0080);
        #1;
        chk("refused_busy", 0, flash_busy);
        rd(3'h2, v);
        chk("refused_status", 16'h00a0, v);
        wr(3'h2, 16'h0030);
        rd(3'h7, v);
        chk("unmapped", 16'h0000, v);
        load('{16'h0340, 16'h0000, 16'h0100, 3'h2, 5'h00, 8'h00});
        wr(3'h2, 16'h0080);
        repeat (5) @(posedge mclk);
        #1;
        chk("busy_running", 1, flash_busy);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(3'h2, v);
        chk("status_rereset", 16'h0080, v);
        rd(3'h1, v);
        chk("index_rereset", 16'h0000, v);
        wrap_up();
    end
endmodule
